//--- rtl/irf_frame_ctrl.sv
`timescale 1ns/1ns
// Contract
// - full duplex keeps receiver open while transmitting
// - in ir modes override forces modem status 30h, no irq
// - mid rate select halves mid bit rate
// - frame end stop halts transmitter in mid or fast mode
// - aux select picks auxiliary receive input
// - terminal count source picks pio or dma
// - irq at threshold or queue time-out
// - eight entry status queue, frames or overrun
// - queue flushed on reset or soft reset
// - push frames in mid or fast mode with dma, reject when full
// - overrun flags for status or data drop
// - checksum mismatch sets checksum error flag
// - physical layer error per mode
// - over maximum length sets length overflow
// - bit six entry type, bit seven valid
// - frame errors also reach line status
// - low length or lost frame count
// - high length bits, read pops entry
// - checksum disable and invert on transmit
// - checksum length per mid and fast mode
// - ask modulation and demodulation disables
// - byte counter loads length, counts down
module irf_frame_ctrl
   import irf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [2:0] i_bank,
   input wire logic [2:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   input wire logic [2:0] i_mode,
   input wire logic i_dma_enable,
   input wire logic i_legacy_dma,
   input wire logic i_dma_transfer,
   input wire logic i_rx_soft_reset,
   input wire logic i_ir_rx_main,
   input wire logic i_ir_rx_aux,
   input wire logic i_tx_active,
   input wire logic [7:0] i_modem_status_raw,
   input wire logic i_modem_irq_raw,
   input wire logic i_mid_bit_tick,
   input wire logic i_tx_frame_start,
   input wire logic i_tx_byte_sent,
   input wire logic [IRF_LEN_W-1:0] i_tx_frame_length,
   input wire logic i_halt_clear,
   input wire logic i_frame_done,
   input wire logic [IRF_LEN_W-1:0] i_frame_len,
   input wire logic [IRF_LEN_W-1:0] i_rx_length_overflow,
   input wire logic [31:0] i_crc_received,
   input wire logic [31:0] i_crc_computed,
   input wire logic i_encoding_error,
   input wire logic i_bof_data_bof,
   input wire logic i_abort_seen,
   input wire logic i_data_queue_drop,
   input wire logic i_queue_timeout,
   output logic o_ir_rx,
   output logic [7:0] o_modem_status,
   output logic o_modem_irq,
   output logic o_mid_bit_en,
   output logic o_halted_on_frame_end,
   output logic o_tx_eof,
   output logic [IRF_LEN_W-1:0] o_tx_byte_count,
   output logic o_crc_append,
   output logic o_crc_invert,
   output logic o_crc32,
   output logic o_ask_mod_en,
   output logic o_ask_demod_en,
   output logic o_status_irq,
   output logic [4:0] o_line_status_err,
   output logic o_frame_reject
);
   localparam int EW = IRF_LEN_W + 8;
   localparam int CW = $clog2(IRF_QUEUE_DEPTH) + 1;

   logic [7:0] ctrl2_r;
   logic [7:0] ctrl3_r;
   logic [7:0] rdata_r;
   logic [1:0] main_sync_r;
   logic [1:0] aux_sync_r;
   logic rx_sel_r;
   logic [7:0] msr_r;
   logic msr_irq_r;
   logic half_r;
   logic bit_en_r;
   logic halted_r;
   logic crc_app_r;
   logic crc_inv_r;
   logic crc32_r;
   logic mod_en_r;
   logic demod_en_r;
   logic irq_r;
   logic tout_r;
   logic [4:0] lsr_err_r;
   logic reject_r;
   logic pend_r;
   logic [7:0] pend_status_r;
   logic [IRF_LEN_W-1:0] pend_len_r;
   logic [7:0] lost_cnt_r;
   logic lost_data_queue_overrun_r;
   logic lost_status_queue_overrun_r;
   logic in_frame_data_queue_overrun_r;

   logic [EW-1:0] q_bottom;
   logic [EW-1:0] q_data;
   logic [CW-1:0] q_count;
   logic q_full;
   logic q_empty;
   logic q_push;
   logic q_pop;
   logic q_flush;
   logic tx_eof;
   logic [IRF_LEN_W-1:0] tx_count;
   logic ir_mode;
   logic hs_mode;
   logic queueing;
   logic crc_bad;
   logic phy_bad;
   logic [7:0] new_status;
   logic push_frame;
   logic push_lost;
   logic drop_frame;
   logic reg_rd;
   logic [3:0] thresh;

   function automatic logic hit(input logic [2:0] bank, input logic [2:0] ofs, input logic [2:0] b,
                                input logic [2:0] a);
      hit = (bank == b) && (ofs == a);
   endfunction : hit

   assign ir_mode = (i_mode != IRF_MODE_UART);
   assign hs_mode = (i_mode == IRF_MODE_MID) || (i_mode == IRF_MODE_FAST);
   assign queueing = hs_mode && i_dma_enable && i_legacy_dma;
   assign q_flush = i_rx_soft_reset;
   assign reg_rd = i_rd && !i_wr;

   assign crc_bad = o_crc32 ? (i_crc_received != i_crc_computed)
                            : (i_crc_received[15:0] != i_crc_computed[15:0]);
   assign phy_bad = (i_mode == IRF_MODE_FAST) ? (i_encoding_error || i_bof_data_bof)
                                              : ((i_mode == IRF_MODE_MID) && i_abort_seen);

   always_comb begin
      new_status = 8'h00;
      new_status[IRF_ST_DATA_QUEUE_OVERRUN] = in_frame_data_queue_overrun_r || i_data_queue_drop;
      new_status[IRF_ST_CRC] = crc_bad;
      new_status[IRF_ST_PHY] = phy_bad;
      new_status[IRF_ST_MAXLEN] = (i_frame_len > i_rx_length_overflow);
   end

   // overrun record first so lost frames are reported in order
   assign push_lost = pend_r && !q_full && (lost_cnt_r != 8'h00 || lost_data_queue_overrun_r || lost_status_queue_overrun_r);
   assign push_frame = pend_r && !q_full && !push_lost;
   assign drop_frame = pend_r && q_full;
   assign q_push = push_lost || push_frame;

   always_comb begin
      q_data = '0;
      if (push_lost) begin
         q_data[IRF_ST_LOST] = 1'b1;
         q_data[IRF_ST_DATA_QUEUE_OVERRUN] = lost_data_queue_overrun_r;
         q_data[IRF_ST_STATUS_QUEUE_OVERRUN] = lost_status_queue_overrun_r;
         q_data[8 +: 8] = lost_cnt_r;
      end else begin
         q_data[7:0] = pend_status_r;
         q_data[8 +: IRF_LEN_W] = pend_len_r;
      end
   end

   assign q_pop = reg_rd && hit(i_bank, i_addr, IRF_BANK_STATUS, IRF_OFS_LEN_HIGH) && !q_empty;

   irf_status_queue #(
      .WIDTH(EW),
      .DEPTH(IRF_QUEUE_DEPTH)
   ) u_queue (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_flush(q_flush),
      .i_push(q_push),
      .i_data(q_data),
      .i_pop(q_pop),
      .o_bottom(q_bottom),
      .o_count(q_count),
      .o_full(q_full),
      .o_empty(q_empty)
   );

   irf_tx_counter u_tx_counter (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_frame_start(i_tx_frame_start),
      .i_byte_sent(i_tx_byte_sent),
      .i_frame_length(i_tx_frame_length),
      .i_tc_source_dma(ctrl2_r[IRF_C2_TC_SOURCE]),
      .i_dma_transfer(i_dma_transfer),
      .o_count(tx_count),
      .o_eof(tx_eof)
   );

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl2_r <= IRF_CTRL2_RST;
         ctrl3_r <= IRF_CTRL3_RST;
      end else if (i_wr) begin
         if (hit(i_bank, i_addr, IRF_BANK_STATUS, IRF_OFS_CTRL2)) begin
            ctrl2_r <= i_wdata & IRF_CTRL2_MASK;
         end
         if (hit(i_bank, i_addr, IRF_BANK_CTRL3, IRF_OFS_CTRL3)) begin
            ctrl3_r <= i_wdata & IRF_CTRL3_MASK;
         end
      end
   end

   // read data, reserved bits read zero
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         rdata_r <= 8'h00;
         if (hit(i_bank, i_addr, IRF_BANK_STATUS, IRF_OFS_CTRL2)) begin
            rdata_r <= ctrl2_r;
         end else if (hit(i_bank, i_addr, IRF_BANK_CTRL3, IRF_OFS_CTRL3)) begin
            rdata_r <= ctrl3_r;
         end else if (!q_empty) begin
            if (hit(i_bank, i_addr, IRF_BANK_STATUS, IRF_OFS_FRAME_STATUS)) begin
               rdata_r <= {1'b1, q_bottom[6], 1'b0, q_bottom[4:0]};
            end else if (hit(i_bank, i_addr, IRF_BANK_STATUS, IRF_OFS_LEN_LOW)) begin
               rdata_r <= q_bottom[8 +: 8];
            end else if (hit(i_bank, i_addr, IRF_BANK_STATUS, IRF_OFS_LEN_HIGH)) begin
               rdata_r <= q_bottom[IRF_ST_LOST] ? 8'h00 : {3'h0, q_bottom[16 +: 5]};
            end
         end
      end
   end

   // two stage sync of both receive pins
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         main_sync_r <= 2'h0;
         aux_sync_r <= 2'h0;
      end else begin
         main_sync_r <= {main_sync_r[0], i_ir_rx_main};
         aux_sync_r <= {aux_sync_r[0], i_ir_rx_aux};
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_sel_r <= 1'b0;
      end else if (i_tx_active && !ctrl2_r[IRF_C2_FULL_DUPLEX]) begin
         rx_sel_r <= 1'b0;
      end else begin
         rx_sel_r <= ctrl2_r[IRF_C2_AUX_RX] ? aux_sync_r[1] : main_sync_r[1];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         msr_r <= 8'h00;
         msr_irq_r <= 1'b0;
      end else if (ir_mode && ctrl2_r[IRF_C2_MSR_OVERRIDE]) begin
         msr_r <= IRF_MSR_FORCED;
         msr_irq_r <= 1'b0;
      end else begin
         msr_r <= i_modem_status_raw;
         msr_irq_r <= i_modem_irq_raw;
      end
   end

   // half rate drops every other tick
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         half_r <= 1'b0;
         bit_en_r <= 1'b0;
      end else begin
         if (i_mid_bit_tick) begin
            half_r <= !half_r;
         end
         bit_en_r <= i_mid_bit_tick && (!ctrl2_r[IRF_C2_MID_RATE] || half_r);
      end
   end

   // halt on counter eof, set wins
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         halted_r <= 1'b0;
      end else if (tx_eof && hs_mode && ctrl2_r[IRF_C2_FRAME_END_STOP]) begin
         halted_r <= 1'b1;
      end else if (i_halt_clear) begin
         halted_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         crc_app_r <= 1'b1;
         crc_inv_r <= 1'b0;
         crc32_r <= 1'b0;
         mod_en_r <= 1'b1;
         demod_en_r <= 1'b1;
      end else begin
         crc_app_r <= !ctrl3_r[IRF_C3_CRC_DIS];
         crc_inv_r <= ctrl3_r[IRF_C3_CRC_INV];
         crc32_r <= (i_mode == IRF_MODE_FAST) ? ctrl3_r[IRF_C3_FAST_CRC32] : ctrl3_r[IRF_C3_MID_CRC32];
         mod_en_r <= !ctrl3_r[IRF_C3_MOD_DIS];
         demod_en_r <= !ctrl3_r[IRF_C3_DEMOD_DIS];
      end
   end

   // one frame stage ahead of the queue; frames arrive far apart
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pend_r <= 1'b0;
         pend_status_r <= 8'h00;
         pend_len_r <= '0;
         in_frame_data_queue_overrun_r <= 1'b0;
      end else if (q_flush) begin
         pend_r <= 1'b0;
         in_frame_data_queue_overrun_r <= 1'b0;
      end else begin
         if (i_frame_done && queueing) begin
            pend_r <= 1'b1;
            pend_status_r <= new_status;
            pend_len_r <= i_frame_len;
         end else if (push_frame || drop_frame) begin
            pend_r <= 1'b0;
         end
         if (i_frame_done) begin
            in_frame_data_queue_overrun_r <= 1'b0;
         end else if (i_data_queue_drop) begin
            in_frame_data_queue_overrun_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lost_cnt_r <= 8'h00;
         lost_data_queue_overrun_r <= 1'b0;
         lost_status_queue_overrun_r <= 1'b0;
         reject_r <= 1'b0;
      end else begin
         reject_r <= drop_frame;
         if (q_flush || push_lost) begin
            lost_cnt_r <= 8'h00;
            lost_data_queue_overrun_r <= 1'b0;
            lost_status_queue_overrun_r <= 1'b0;
         end else if (drop_frame) begin
            if (lost_cnt_r != 8'hff) begin
               lost_cnt_r <= lost_cnt_r + 8'h01;
            end
            lost_status_queue_overrun_r <= 1'b1;
            lost_data_queue_overrun_r <= lost_data_queue_overrun_r || pend_status_r[IRF_ST_DATA_QUEUE_OVERRUN];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lsr_err_r <= 5'h00;
      end else begin
         lsr_err_r <= push_frame ? pend_status_r[4:0] : (push_lost ? q_data[4:0] : 5'h00);
      end
   end

   assign thresh = ctrl2_r[IRF_C2_THRESH_SEL] ? IRF_THRESH_HIGH : IRF_THRESH_LOW;

   // threshold or time-out, time-out set wins over pop
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tout_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         // flush first, else a stale latch holds irq on an empty queue
         if (q_flush) begin
            tout_r <= 1'b0;
         end else if (i_queue_timeout && !q_empty) begin
            tout_r <= 1'b1;
         end else if (q_pop) begin
            tout_r <= 1'b0;
         end
         irq_r <= (4'(q_count) >= thresh) || tout_r;
      end
   end

   assign o_rdata = rdata_r;
   assign o_ir_rx = rx_sel_r;
   assign o_modem_status = msr_r;
   assign o_modem_irq = msr_irq_r;
   assign o_mid_bit_en = bit_en_r;
   assign o_halted_on_frame_end = halted_r;
   assign o_tx_eof = tx_eof;
   assign o_tx_byte_count = tx_count;
   assign o_crc_append = crc_app_r;
   assign o_crc_invert = crc_inv_r;
   assign o_crc32 = crc32_r;
   assign o_ask_mod_en = mod_en_r;
   assign o_ask_demod_en = demod_en_r;
   assign o_status_irq = irq_r;
   assign o_line_status_err = lsr_err_r;
   assign o_frame_reject = reject_r;
endmodule : irf_frame_ctrl

//--- common/irf_pkg.sv
package irf_pkg;
   // operating modes as seen by this block
   typedef enum logic [2:0] {
      IRF_MODE_UART = 3'h0,
      IRF_MODE_ASK = 3'h1,
      IRF_MODE_SIR = 3'h2,
      IRF_MODE_MID = 3'h3,
      IRF_MODE_FAST = 3'h4,
      IRF_MODE_CONS = 3'h5
   } irf_mode_t;

   // banks and offsets
   localparam logic [2:0] IRF_BANK_STATUS = 3'h5;
   localparam logic [2:0] IRF_BANK_CTRL3 = 3'h6;
   localparam logic [2:0] IRF_OFS_CTRL2 = 3'h4;
   localparam logic [2:0] IRF_OFS_FRAME_STATUS = 3'h5;
   localparam logic [2:0] IRF_OFS_LEN_LOW = 3'h6;
   localparam logic [2:0] IRF_OFS_LEN_HIGH = 3'h7;
   localparam logic [2:0] IRF_OFS_CTRL3 = 3'h0;

   // reset values and writable masks
   localparam logic [7:0] IRF_CTRL2_RST = 8'h02;
   localparam logic [7:0] IRF_CTRL2_MASK = 8'h7f;
   localparam logic [7:0] IRF_CTRL3_RST = 8'h20;
   localparam logic [7:0] IRF_CTRL3_MASK = 8'hf6;

   // control two fields
   localparam int IRF_C2_FULL_DUPLEX = 0;
   localparam int IRF_C2_MSR_OVERRIDE = 1;
   localparam int IRF_C2_MID_RATE = 2;
   localparam int IRF_C2_FRAME_END_STOP = 3;
   localparam int IRF_C2_AUX_RX = 4;
   localparam int IRF_C2_TC_SOURCE = 5;
   localparam int IRF_C2_THRESH_SEL = 6;

   // control three fields
   localparam int IRF_C3_CRC_DIS = 1;
   localparam int IRF_C3_CRC_INV = 2;
   localparam int IRF_C3_MID_CRC32 = 4;
   localparam int IRF_C3_FAST_CRC32 = 5;
   localparam int IRF_C3_MOD_DIS = 6;
   localparam int IRF_C3_DEMOD_DIS = 7;

   // frame status byte fields
   localparam int IRF_ST_STATUS_QUEUE_OVERRUN = 0;
   localparam int IRF_ST_DATA_QUEUE_OVERRUN = 1;
   localparam int IRF_ST_CRC = 2;
   localparam int IRF_ST_PHY = 3;
   localparam int IRF_ST_MAXLEN = 4;
   localparam int IRF_ST_LOST = 6;
   localparam int IRF_ST_VALID = 7;

   localparam int IRF_LEN_W = 13;
   localparam int IRF_QUEUE_DEPTH = 8;
   localparam logic [3:0] IRF_THRESH_LOW = 4'h2;
   localparam logic [3:0] IRF_THRESH_HIGH = 4'h4;
   localparam logic [7:0] IRF_MSR_FORCED = 8'h30;
endpackage : irf_pkg

//--- rtl/irf_status_queue.sv
`timescale 1ns/1ns
module irf_status_queue #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_flush,
   input wire logic i_push,
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_pop,
   output logic [WIDTH-1:0] o_bottom,
   output logic [$clog2(DEPTH):0] o_count,
   output logic o_full,
   output logic o_empty
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_push;
   logic do_pop;

   assign o_full = (count_r == (AW+1)'(DEPTH));
   assign o_empty = (count_r == '0);
   assign do_push = i_push && !o_full;
   assign do_pop = i_pop && !o_empty;
   assign o_bottom = mem_r[rd_ptr_r];
   assign o_count = count_r;

   always_ff @(posedge i_clk) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (i_flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : irf_status_queue

//--- rtl/irf_tx_counter.sv
`timescale 1ns/1ns
module irf_tx_counter
   import irf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_frame_start,
   input wire logic i_byte_sent,
   input wire logic [IRF_LEN_W-1:0] i_frame_length,
   input wire logic i_tc_source_dma,
   input wire logic i_dma_transfer,
   output logic [IRF_LEN_W-1:0] o_count,
   output logic o_eof
);
   logic [IRF_LEN_W-1:0] count_r;
   logic eof_r;
   logic tc_now;

   assign o_count = count_r;
   assign o_eof = eof_r;
   assign tc_now = i_byte_sent && !i_frame_start && (count_r == IRF_LEN_W'(1));

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_r <= '0;
      end else if (i_frame_start) begin
         count_r <= i_frame_length;
      end else if (i_byte_sent && count_r != '0) begin
         count_r <= count_r - 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         eof_r <= 1'b0;
      end else begin
         eof_r <= tc_now && (i_tc_source_dma == i_dma_transfer);
      end
   end
endmodule : irf_tx_counter

//--- dv/irf_frame_ctrl_chk.sv
`timescale 1ns/1ns
module irf_chk
   import irf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [2:0] i_mode,
   input wire logic [7:0] i_modem_status_raw,
   input wire logic i_modem_irq_raw,
   input wire logic i_ir_rx_main,
   input wire logic i_ir_rx_aux,
   input wire logic i_mid_bit_tick,
   input wire logic i_tx_frame_start,
   input wire logic i_tx_byte_sent,
   input wire logic [IRF_LEN_W-1:0] i_tx_frame_length,
   input wire logic i_halt_clear,
   input wire logic o_ir_rx,
   input wire logic [7:0] o_modem_status,
   input wire logic o_modem_irq,
   input wire logic o_mid_bit_en,
   input wire logic o_halted_on_frame_end,
   input wire logic o_tx_eof,
   input wire logic [IRF_LEN_W-1:0] o_tx_byte_count
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence load_s;
      i_tx_frame_start && !i_tx_byte_sent;
   endsequence
   sequence step_s;
      i_tx_byte_sent && !i_tx_frame_start && o_tx_byte_count != 13'h0;
   endsequence
   uart_modem_a: assert property (i_mode == 3'h0 |=>
      o_modem_status == $past(i_modem_status_raw) && o_modem_irq == $past(i_modem_irq_raw))
      else $error("modem status not passed in uart mode");
   ir_modem_a: assert property (i_mode != 3'h0 |=> (o_modem_status == 8'h30 && !o_modem_irq) ||
      (o_modem_status == $past(i_modem_status_raw) && o_modem_irq == $past(i_modem_irq_raw)))
      else $error("modem status neither forced nor passed");
   rx_source_a: assert property (o_ir_rx |-> $past(i_ir_rx_main, 3) || $past(i_ir_rx_aux, 3))
      else $error("receive output without a pin high");
   mid_tick_a: assert property (o_mid_bit_en |-> $past(i_mid_bit_tick))
      else $error("mid bit enable without tick");
   count_load_a: assert property (load_s |=> o_tx_byte_count == $past(i_tx_frame_length))
      else $error("byte counter not loaded");
   count_step_a: assert property (step_s |=> o_tx_byte_count == $past(o_tx_byte_count) - 13'h1)
      else $error("byte counter not decremented");
   eof_cause_a: assert property (o_tx_eof |-> $past(i_tx_byte_sent) && $past(o_tx_byte_count) == 13'h1)
      else $error("end of frame without terminal count");
   halt_hold_a: assert property (o_halted_on_frame_end && !i_halt_clear |=> o_halted_on_frame_end)
      else $error("halted flag dropped without clear");
endmodule : irf_chk

//--- dv/irf_host_model.sv
`timescale 1ns/1ns
module irf_host_model (
   input wire logic i_clk,
   output logic [2:0] o_bank = 3'h0,
   output logic [2:0] o_addr = 3'h0,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0,
   output logic [7:0] o_wdata = 8'h00
);
   logic [7:0] exp_q[$];
   // one access per call; for reads d is the expected data
   task automatic xfer(input logic w, input logic [2:0] b, input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_bank = b;
      o_addr = a;
      o_wdata = w ? d : ~o_wdata;
      o_wr = w;
      o_rd = !w;
      if (!w) exp_q.push_back(d);
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      // released data inverted so a stale byte never looks valid
      o_wdata = ~o_wdata;
   endtask : xfer
   task automatic entry(input logic [23:0] e);
      xfer(1'b0, 3'h5, 3'h5, e[23:16]);
      xfer(1'b0, 3'h5, 3'h6, e[15:8]);
      xfer(1'b0, 3'h5, 3'h7, e[7:0]);
   endtask : entry
endmodule : irf_host_model

//--- dv/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic i_clk = 1'b0, i_resetn = 1'b0, i_wr, i_rd, i_dma_transfer = 1'b0, i_rx_soft_reset = 1'b0;
   logic i_ir_rx_main = 1'b0, i_ir_rx_aux = 1'b0, i_tx_active = 1'b0, i_modem_irq_raw = 1'b0;
   logic i_mid_bit_tick = 1'b0, i_tx_frame_start = 1'b0, i_tx_byte_sent = 1'b0, i_halt_clear = 1'b0;
   logic i_frame_done = 1'b0, i_encoding_error = 1'b0, i_abort_seen = 1'b0, i_queue_timeout = 1'b0;
   logic i_dma_enable = 1'b1, i_legacy_dma = 1'b1, i_bof_data_bof = 1'b0, i_data_queue_drop = 1'b0;
   logic [2:0] i_bank, i_addr, i_mode = 3'h0;
   logic [7:0] i_wdata, o_rdata, o_modem_status, i_modem_status_raw = 8'h00;
   logic [12:0] i_tx_frame_length = 13'h0, i_frame_len = 13'h0, i_rx_length_overflow = 13'h0, o_tx_byte_count;
   logic [31:0] i_crc_received = 32'h0, i_crc_computed = 32'h0;
   logic [4:0] o_line_status_err;
   logic o_ir_rx, o_modem_irq, o_mid_bit_en, o_halted_on_frame_end, o_tx_eof, o_crc_append, o_crc_invert;
   logic o_crc32, o_ask_mod_en, o_ask_demod_en, o_status_irq, o_frame_reject, rd_d = 1'b0;
   logic [15:0] rnd = 16'he2df, bg = 16'he2df;
   logic [23:0] ent_q[$];
   int err_count = 0, cmp_count = 0, cyc = 0;
   irf_frame_ctrl u_irf_frame_ctrl (.*);
   irf_host_model u_irf_host_model (.i_clk(i_clk), .o_bank(i_bank), .o_addr(i_addr), .o_wr(i_wr),
      .o_rd(i_rd), .o_wdata(i_wdata));
   always #20 i_clk = ~i_clk;
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wt
   // f: 0 crc low, 1 encoding, 2 abort, 3 too long, 4 crc high half
   task automatic fr(input logic [12:0] len, input logic [4:0] f, input logic acc, input logic rec);
      logic [4:0] st;
      logic [4:0] seen;
      logic rj;
      st = {f[3], i_mode == 3'h4 ? f[1] : f[2], f[0] | (i_mode == 3'h4 & f[4]), i_data_queue_drop, 1'b0};
      seen = 5'h0;
      rj = 1'b0;
      if (rec) ent_q.push_back(24'hc10200);
      if (acc) ent_q.push_back({3'b100, st, len[7:0], 3'b000, len[12:8]});
      i_frame_done = 1'b1;
      i_frame_len = len;
      i_rx_length_overflow = f[3] ? len - 13'h1 : len;
      i_crc_received = 32'h5a5a1234;
      i_crc_computed = {16'h5a5a ^ {16{f[4]}}, 16'h1234 ^ {15'h0, f[0]}};
      i_encoding_error = f[1];
      i_abort_seen = f[2];
      wt(1);
      i_frame_done = 1'b0;
      i_data_queue_drop = 1'b0;
      i_frame_len = ~len;
      // six cycles also keeps frames legally spaced
      repeat (6) begin
         wt(1);
         seen |= o_line_status_err;
         rj |= o_frame_reject;
      end
      check("reject", rj, !acc);
      if (acc) check("line status", seen, st | {4'h0, rec});
   endtask : fr
   always @(posedge i_clk) begin
      #1;
      bg = nxt(bg);
      i_mid_bit_tick = bg[0];
      i_modem_irq_raw = bg[1];
      i_modem_status_raw = bg[15:8];
   end
   always @(posedge i_clk) begin
      cyc++;
      if (rd_d) check("rdata", o_rdata, u_irf_host_model.exp_q.pop_front());
      rd_d <= i_rd & ~i_wr;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      wt(2);
      i_resetn = 1'b1;
      u_irf_host_model.xfer(1'b0, 3'h5, 3'h4, 8'h02);
      u_irf_host_model.xfer(1'b0, 3'h6, 3'h0, 8'h20);
      u_irf_host_model.xfer(1'b0, 3'h5, 3'h5, 8'h00);
      u_irf_host_model.xfer(1'b0, 3'h5, 3'h7, 8'h00);
      u_irf_host_model.xfer(1'b0, 3'h6, 3'h5, 8'h00);
      i_mode = 3'h4;
      repeat (4) begin
         rnd = nxt(rnd);
         u_irf_host_model.xfer(1'b1, 3'h5, 3'h4, rnd[7:0]);
         u_irf_host_model.xfer(1'b0, 3'h5, 3'h4, rnd[7:0] & 8'h7f);
         u_irf_host_model.xfer(1'b1, 3'h6, 3'h0, rnd[15:8]);
         u_irf_host_model.xfer(1'b0, 3'h6, 3'h0, rnd[15:8] & 8'hf6);
      end
      check("crc ctl", {o_crc_append, o_crc_invert, o_crc32, o_ask_mod_en, o_ask_demod_en},
         {!rnd[9], rnd[10], rnd[13], !rnd[14], !rnd[15]});
      u_irf_host_model.xfer(1'b1, 3'h6, 3'h0, 8'h20);
      u_irf_host_model.xfer(1'b1, 3'h5, 3'h4, 8'h00);
      fr(13'h0123, 5'h01, 1'b1, 1'b0);
      check("irq", o_status_irq, 1'b0);
      fr(13'h1abc, 5'h02, 1'b1, 1'b0);
      check("irq", o_status_irq, 1'b1);
      i_data_queue_drop = 1'b1;
      fr(13'h0040, 5'h0c, 1'b1, 1'b0);
      i_mode = 3'h3;
      // checksum length follows the mode one cycle later
      wt(1);
      fr(13'h0fff, 5'h16, 1'b1, 1'b0);
      i_mode = 3'h4;
      while (ent_q.size() > 0) u_irf_host_model.entry(ent_q.pop_front());
      for (int i = 0; i < 10; i++) begin
         rnd = nxt(rnd);
         fr(rnd[12:0], 5'h00, i < 8, 1'b0);
      end
      while (ent_q.size() > 0) u_irf_host_model.entry(ent_q.pop_front());
      fr(13'h0002, 5'h00, 1'b1, 1'b1);
      while (ent_q.size() > 0) u_irf_host_model.entry(ent_q.pop_front());
      u_irf_host_model.xfer(1'b0, 3'h5, 3'h7, 8'h00);
      fr(13'h0055, 5'h00, 1'b1, 1'b0);
      check("irq", o_status_irq, 1'b0);
      i_queue_timeout = 1'b1;
      wt(1);
      i_queue_timeout = 1'b0;
      wt(1);
      check("irq", o_status_irq, 1'b1);
      ent_q.delete();
      i_rx_soft_reset = 1'b1;
      wt(1);
      i_rx_soft_reset = 1'b0;
      u_irf_host_model.xfer(1'b0, 3'h5, 3'h5, 8'h00);
      check("irq", o_status_irq, 1'b0);
      u_irf_host_model.xfer(1'b1, 3'h5, 3'h4, 8'h08);
      for (int k = 0; k < 2; k++) begin
         i_dma_transfer = k == 0;
         i_tx_frame_length = 13'h3;
         i_tx_frame_start = 1'b1;
         wt(1);
         i_tx_frame_start = 1'b0;
         repeat (3) begin
            i_tx_byte_sent = 1'b1;
            wt(1);
            i_tx_byte_sent = 1'b0;
            wt(1);
         end
         wt(1);
         check("count", o_tx_byte_count, 13'h0);
         check("halt", o_halted_on_frame_end, k == 1);
      end
      i_halt_clear = 1'b1;
      wt(1);
      i_halt_clear = 1'b0;
      wt(1);
      check("halt", o_halted_on_frame_end, 1'b0);
      i_ir_rx_main = 1'b1;
      i_tx_active = 1'b1;
      wt(5);
      check("rx", o_ir_rx, 1'b0);
      i_tx_active = 1'b0;
      wt(5);
      check("rx", o_ir_rx, 1'b1);
      u_irf_host_model.xfer(1'b1, 3'h5, 3'h4, 8'h13);
      i_ir_rx_main = 1'b0;
      i_ir_rx_aux = 1'b1;
      i_tx_active = 1'b1;
      wt(5);
      check("rx", o_ir_rx, 1'b1);
      check("msr", o_modem_status, 8'h30);
      end_sim();
   end
endmodule : testbench
bind irf_frame_ctrl irf_chk u_irf_chk (.*);
